// File: logic/oss_defines.vh
/*
 Constants for the second-operand shifter and status-word update logic.
 Assumes inclusion by bare name from the design files.
*/
`ifndef OSS_DEFINES_VH
`define OSS_DEFINES_VH
// Shift type encodings
`define OSS_SH_LSL      2'h0
`define OSS_SH_LSR      2'h1
`define OSS_SH_ASR      2'h2
`define OSS_SH_ROR      2'h3
// Opcode encodings used by this block
`define OSS_OP_TST      4'h8
`define OSS_OP_TEQ      4'h9
`define OSS_OP_CMP      4'ha
`define OSS_OP_CMN      4'hb
// Status word field positions
`define OSS_N_BIT       31
`define OSS_Z_BIT       30
`define OSS_C_BIT       29
`define OSS_V_BIT       28
`define OSS_I_BIT       7
`define OSS_F_BIT       6
`define OSS_T_BIT       5
// Mask of defined status bits (flags, I, F, T, mode)
`define OSS_DEF_MASK    32'hf000_00ff
`define OSS_FLAG_MASK   32'hf000_0000
`define OSS_CTRL_MASK   32'h0000_00ff
// Mode values
`define OSS_MODE_USR    5'h10
`define OSS_MODE_FIQ    5'h11
`define OSS_MODE_IRQ    5'h12
`define OSS_MODE_SVC    5'h13
`define OSS_MODE_ABT    5'h17
`define OSS_MODE_UND    5'h1b
// Reset value of the current status word: supervisor, I and F set
`define OSS_PSR_RST     32'h0000_00d3
// Program counter read-ahead
`define OSS_PC_AHEAD_IMM 32'h0000_0008
`define OSS_PC_AHEAD_REG 32'h0000_000c
// Wishbone register offsets
`define OSS_REG_CTRL    4'h0
`define OSS_REG_PSR     4'h4
`define OSS_REG_CYC     4'h8
`define OSS_REG_SAVED_STATUS_WORD    4'hc
`endif

// File: logic/oss_shifter.v
/*
 Combinational barrel shifter for the second operand.
 Assumes a 32-bit operand, the low byte of the amount register and the
 current carry flag are stable for the evaluating cycle.
*/
`timescale 1ns/1ns
`include "oss_defines.vh"
module oss_shifter (
   input  wire [31:0] operand_i,
   input  wire [1:0]  type_i,
   input  wire [7:0]  amount_i,
   input  wire        by_reg_i,
   input  wire        carry_i,
   output reg  [31:0] result_o,
   output reg         carry_o
);
   reg [4:0]  amt5;
   reg [63:0] dbl;
   reg [32:0] ext;

   // Shift selection with all special encodings
   always @* begin
      amt5     = amount_i[4:0];
      dbl      = {operand_i, operand_i};
      ext      = 33'h0_0000_0000;
      result_o = operand_i;
      carry_o  = carry_i;
      if (!by_reg_i && amt5 == 5'h00) begin
         case (type_i)
            `OSS_SH_LSL: begin
               result_o = operand_i;
               carry_o  = carry_i;
            end
            `OSS_SH_LSR: begin
               result_o = 32'h0000_0000;
               carry_o  = operand_i[31];
            end
            `OSS_SH_ASR: begin
               result_o = {32{operand_i[31]}};
               carry_o  = operand_i[31];
            end
            default: begin
               result_o = {carry_i, operand_i[31:1]};
               carry_o  = operand_i[0];
            end
         endcase
      end else if (by_reg_i && amount_i == 8'h00) begin
         result_o = operand_i;
         carry_o  = carry_i;
      end else if (!by_reg_i || amount_i < 8'd32) begin
         // Amounts 1 to 31 behave identically for both sources
         case (type_i)
            `OSS_SH_LSL: begin
               ext      = {1'b0, operand_i} << amt5;
               result_o = ext[31:0];
               carry_o  = ext[32];
            end
            `OSS_SH_LSR: begin
               result_o = operand_i >> amt5;
               carry_o  = operand_i[amt5 - 5'd1];
            end
            `OSS_SH_ASR: begin
               result_o = $signed(operand_i) >>> amt5;
               carry_o  = operand_i[amt5 - 5'd1];
            end
            default: begin
               dbl      = dbl >> amt5;
               result_o = dbl[31:0];
               carry_o  = operand_i[amt5 - 5'd1];
            end
         endcase
      end else begin
         case (type_i)
            `OSS_SH_LSL: begin
               result_o = 32'h0000_0000;
               carry_o  = (amount_i == 8'd32) ? operand_i[0] : 1'b0;
            end
            `OSS_SH_LSR: begin
               result_o = 32'h0000_0000;
               carry_o  = (amount_i == 8'd32) ? operand_i[31] : 1'b0;
            end
            `OSS_SH_ASR: begin
               result_o = {32{operand_i[31]}};
               carry_o  = operand_i[31];
            end
            default: begin
               if (amt5 == 5'h00) begin
                  result_o = operand_i;
                  carry_o  = operand_i[31];
               end else begin
                  dbl      = dbl >> amt5;
                  result_o = dbl[31:0];
                  carry_o  = operand_i[amt5 - 5'd1];
               end
            end
         endcase
      end
   end
endmodule // oss_shifter

// File: logic/oss_psr_bank.v
/*
 Banked saved status words, one per privileged mode.
 Assumes the mode field of the current status word selects the bank.
*/
`timescale 1ns/1ns
`include "oss_defines.vh"
module oss_psr_bank (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire [4:0]  mode_i,
   input  wire        we_i,
   input  wire [31:0] wmask_i,
   input  wire [31:0] wdata_i,
   output wire [31:0] rdata_o,
   output wire        valid_o
);
   reg [31:0] bank_q [0:4];
   reg [2:0]  sel;
   reg        ok;
   integer    i;

   // Mode to bank index
   always @* begin
      sel = 3'd0;
      ok  = 1'b1;
      case (mode_i)
         `OSS_MODE_FIQ: sel = 3'd0;
         `OSS_MODE_IRQ: sel = 3'd1;
         `OSS_MODE_SVC: sel = 3'd2;
         `OSS_MODE_ABT: sel = 3'd3;
         `OSS_MODE_UND: sel = 3'd4;
         default:       ok  = 1'b0;
      endcase
   end

   // Masked write into the current mode's copy
   always @(posedge clk_i) begin
      if (rst_i) begin
         for (i = 0; i < 5; i = i + 1)
            bank_q[i] <= 32'h0000_0000;
      end else if (we_i && ok) begin
         bank_q[sel] <= (bank_q[sel] & ~wmask_i) | (wdata_i & wmask_i);
      end
   end

   assign rdata_o = ok ? bank_q[sel] : 32'h0000_0000;
   assign valid_o = ok;
endmodule // oss_psr_bank

// File: logic/oss_top.v
/*
 Operand shifter and status-word update for data processing and status
 transfer instructions. Decoded fields arrive from the instruction decoder
 with exec_i; register values come from the register file. Software reads
 state and sets the flag-update enable through a classic Wishbone slave.
*/
`timescale 1ns/1ns
`include "oss_defines.vh"
module oss_top (
   input  wire        clk_i,
   input  wire        rst_i,
   // Wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [3:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   // Decoded instruction
   input  wire        exec_i,
   input  wire [31:0] instr_i,
   input  wire [31:0] op1_i,
   input  wire [31:0] operand_register_i,
   input  wire [31:0] shift_amount_register_i,
   input  wire        op1_is_pc_i,
   input  wire        op2_is_pc_i,
   input  wire [31:0] instr_addr_i,
   input  wire [31:0] alu_result_i,
   input  wire        alu_carry_i,
   input  wire        alu_ovf_i,
   // Results
   output reg  [31:0] op2_o,
   output reg         shift_carry_o,
   output reg  [31:0] op1_o,
   output reg  [31:0] rd_data_o,
   output reg         rd_we_o,
   output reg         pc_we_o,
   output reg         undef_o,
   output reg  [1:0]  cyc_s_o,
   output reg  [1:0]  cyc_n_o,
   output reg  [1:0]  cyc_i_o,
   output reg  [31:0] current_status_word_o
);
   reg  [31:0] psr_q;
   reg  [31:0] psr_d;
   reg  [31:0] cyc_cnt_q;
   reg         flags_en_q;

   // Instruction fields
   wire        imm_op   = instr_i[25];
   wire [3:0]  opcode   = instr_i[24:21];
   wire        set_fl   = instr_i[20];
   wire [3:0]  rd_idx   = instr_i[15:12];
   wire        by_reg   = instr_i[4];
   wire [1:0]  sh_type  = instr_i[6:5];
   wire [4:0]  sh_imm   = instr_i[11:7];
   wire [3:0]  rot_fld  = instr_i[11:8];
   wire [7:0]  imm8     = instr_i[7:0];
   wire        dest_pc  = (rd_idx == 4'hf);
   wire        user     = (psr_q[4:0] == `OSS_MODE_USR);
   wire        test_op  = (opcode[3:2] == 2'b10);
   wire        xfer     = test_op && !set_fl;
   wire        bad_reg  = !imm_op && by_reg && instr_i[7];

   // Program counter read-ahead by shift source
   wire [31:0] pc_val = instr_addr_i + ((!imm_op && by_reg) ?
                        `OSS_PC_AHEAD_REG : `OSS_PC_AHEAD_IMM);
   wire [31:0] rm_val = op2_is_pc_i ? pc_val : operand_register_i;

   // Immediate rotation by twice the rotate field
   wire [63:0] imm_dbl = {24'h00_0000, imm8, 24'h00_0000, imm8};
   wire [63:0] imm_rot = imm_dbl >> {rot_fld, 1'b0};
   wire [31:0] imm_val = imm_rot[31:0];
   wire        imm_cy  = (rot_fld == 4'h0) ? psr_q[`OSS_C_BIT] : imm_val[31];

   wire [31:0] sh_res;
   wire        sh_cy;
   wire [7:0]  sh_amt = by_reg ? shift_amount_register_i[7:0]
                               : {3'b000, sh_imm};

   oss_shifter u_shift (
      .operand_i (rm_val),
      .type_i    (sh_type),
      .amount_i  (sh_amt),
      .by_reg_i  (by_reg),
      .carry_i   (psr_q[`OSS_C_BIT]),
      .result_o  (sh_res),
      .carry_o   (sh_cy)
   );

   wire [31:0] saved_status_word_val;
   wire        saved_status_word_ok;
   reg         saved_status_word_we;
   reg  [31:0] saved_status_word_mask;
   reg  [31:0] saved_status_word_wdata;

   oss_psr_bank u_bank (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .mode_i  (psr_q[4:0]),
      .we_i    (saved_status_word_we),
      .wmask_i (saved_status_word_mask),
      .wdata_i (saved_status_word_wdata),
      .rdata_o (saved_status_word_val),
      .valid_o (saved_status_word_ok)
   );

   wire [31:0] op2_val = imm_op ? imm_val : sh_res;
   wire        op2_cy  = imm_op ? imm_cy : sh_cy;
   wire        logical = (opcode == 4'h0) || (opcode == 4'h1) ||
                         (opcode == `OSS_OP_TST) ||
                         (opcode == `OSS_OP_TEQ) || (opcode[3:2] == 2'b11);
   // Transfer source: register or immediate
   wire [31:0] xfer_src = imm_op ? imm_val : operand_register_i;
   // Writable bits of the current word for a full transfer
   wire [31:0] cur_mask = (user ? `OSS_FLAG_MASK : `OSS_DEF_MASK);
   wire [31:0] fl_mask  = instr_i[16] ? cur_mask : `OSS_FLAG_MASK;

   // Status-word next value and bank writes
   always @* begin
      psr_d      = psr_q;
      saved_status_word_we    = 1'b0;
      saved_status_word_mask  = `OSS_DEF_MASK;
      saved_status_word_wdata = xfer_src;
      if (exec_i && !bad_reg) begin
         if (xfer) begin
            if (instr_i[21]) begin
               if (instr_i[22]) begin
                  saved_status_word_we   = 1'b1;
                  saved_status_word_mask = instr_i[16] ? `OSS_DEF_MASK : `OSS_FLAG_MASK;
               end else begin
                  // Reserved bits keep their stored value
                  psr_d = (psr_q & ~fl_mask) | (xfer_src & fl_mask);
               end
            end
         end else if (dest_pc && set_fl) begin
            if (!(opcode == `OSS_OP_TEQ && user) && saved_status_word_ok)
               psr_d = saved_status_word_val;
         end else if (set_fl && flags_en_q) begin
            psr_d[`OSS_N_BIT] = alu_result_i[31];
            psr_d[`OSS_Z_BIT] = (alu_result_i == 32'h0000_0000);
            if (logical) begin
               psr_d[`OSS_C_BIT] = op2_cy;
            end else begin
               psr_d[`OSS_C_BIT] = alu_carry_i;
               psr_d[`OSS_V_BIT] = alu_ovf_i;
            end
         end
      end
   end

   // Registered outputs and status word
   always @(posedge clk_i) begin
      if (rst_i) begin
         psr_q         <= `OSS_PSR_RST;
         op2_o         <= 32'h0000_0000;
         shift_carry_o <= 1'b0;
         op1_o         <= 32'h0000_0000;
         rd_data_o     <= 32'h0000_0000;
         rd_we_o       <= 1'b0;
         pc_we_o       <= 1'b0;
         undef_o       <= 1'b0;
         cyc_s_o       <= 2'd0;
         cyc_n_o       <= 2'd0;
         cyc_i_o       <= 2'd0;
      end else begin
         psr_q   <= psr_d;
         rd_we_o <= 1'b0;
         pc_we_o <= 1'b0;
         undef_o <= 1'b0;
         if (exec_i) begin
            op2_o         <= op2_val;
            shift_carry_o <= op2_cy;
            op1_o         <= op1_is_pc_i ? pc_val : op1_i;
            undef_o       <= bad_reg;
            if (!bad_reg) begin
               if (xfer) begin
                  // Status read into a general register
                  rd_data_o <= instr_i[22] ? saved_status_word_val : psr_q;
                  rd_we_o   <= !instr_i[21];
                  cyc_s_o   <= 2'd1;
                  cyc_n_o   <= 2'd0;
                  cyc_i_o   <= 2'd0;
               end else begin
                  rd_data_o <= alu_result_i;
                  rd_we_o   <= !test_op && !dest_pc;
                  pc_we_o   <= dest_pc && !test_op;
                  cyc_s_o   <= dest_pc ? 2'd2 : 2'd1;
                  cyc_n_o   <= dest_pc ? 2'd1 : 2'd0;
                  cyc_i_o   <= (!imm_op && by_reg) ? 2'd1 : 2'd0;
               end
            end
         end
      end
   end

   always @* current_status_word_o = psr_q;

   // Instruction counter and flag enable control
   always @(posedge clk_i) begin
      if (rst_i) begin
         cyc_cnt_q  <= 32'h0000_0000;
         flags_en_q <= 1'b1;
      end else begin
         if (exec_i)
            cyc_cnt_q <= cyc_cnt_q + 32'h0000_0001;
         if (cyc_i && stb_i && we_i && !ack_o &&
             adr_i == `OSS_REG_CTRL && sel_i[0])
            flags_en_q <= dat_i[0];
      end
   end

   // Wishbone answer one cycle after request, dropped the next
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
         case (adr_i)
            `OSS_REG_CTRL: dat_o <= {31'h0000_0000, flags_en_q};
            `OSS_REG_PSR:  dat_o <= psr_q & `OSS_DEF_MASK;
            `OSS_REG_CYC:  dat_o <= cyc_cnt_q;
            `OSS_REG_SAVED_STATUS_WORD: dat_o <= saved_status_word_val;
            default:       dat_o <= 32'h0000_0000;
         endcase
      end
   end
endmodule // oss_top

// File: bench/oss_chk.sv
/* Checker on the ports of oss_top.
   Assumes it is bound into oss_top from the bench. */
`timescale 1ns/1ns
module oss_chk (
   input wire        clk_i,
   input wire        rst_i,
   input wire        cyc_i,
   input wire        stb_i,
   input wire        ack_o,
   input wire        exec_i,
   input wire [31:0] instr_i,
   input wire [31:0] operand_register_i,
   input wire        op2_is_pc_i,
   input wire [31:0] op2_o,
   input wire        shift_carry_o,
   input wire        rd_we_o,
   input wire        pc_we_o,
   input wire        undef_o,
   input wire [31:0] current_status_word_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [31:0] rm_q;
   logic        c_q;
   // Register-operand data op, status transfers left out
   wire dp = exec_i && instr_i[27:25] == 3'h0 && !op2_is_pc_i &&
             !(instr_i[24:23] == 2'h2 && !instr_i[20]);
   // Writes the program counter without flag setting
   wire pcw = exec_i && instr_i[27:26] == 2'h0 && !instr_i[20] &&
              instr_i[15:12] == 4'hf && instr_i[24:23] != 2'h2 &&
              !(!instr_i[25] && instr_i[7] && instr_i[4]);
   // Operand and carry seen at the evaluating edge
   always @(posedge clk_i) begin
      rm_q <= operand_register_i;
      c_q  <= current_status_word_o[29];
   end
   AST_LSL0: assert property (
      dp && instr_i[11:4] == 8'h00 |=> op2_o == rm_q && shift_carry_o == c_q)
      else $error("shift zero bad");
   AST_LSR32: assert property (
      dp && instr_i[11:4] == 8'h02 |=> op2_o == 0 && shift_carry_o == rm_q[31])
      else $error("lsr32 bad");
   AST_ASR32: assert property (
      dp && instr_i[11:4] == 8'h04 |=>
      op2_o == {32{rm_q[31]}} && shift_carry_o == rm_q[31])
      else $error("asr32 bad");
   AST_RRX: assert property (
      dp && instr_i[11:4] == 8'h06 |=>
      op2_o == {c_q, rm_q[31:1]} && shift_carry_o == rm_q[0])
      else $error("rrx bad");
   AST_UNDEF: assert property (
      exec_i && instr_i[27:25] == 3'h0 && instr_i[7] && instr_i[4] |=>
      undef_o && !rd_we_o && !pc_we_o)
      else $error("undef bad");
   AST_TEST: assert property (
      exec_i && instr_i[27:26] == 2'h0 && instr_i[24:23] == 2'h2 &&
      instr_i[20] |=> !rd_we_o)
      else $error("test op wrote");
   AST_PCW: assert property (
      pcw |=> pc_we_o && $stable(current_status_word_o))
      else $error("pc write bad");
   AST_ACK: assert property (
      cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("ack bad");
   // Main scenarios reached
   cover property (undef_o);
   cover property (pc_we_o);
   cover property (ack_o);
endmodule // oss_chk

// File: bench/oss_partner.sv
/* Decoder and register file model, one instruction per call.
   Assumes clk_i is the core clock. */
`timescale 1ns/1ns
module oss_partner (
   output reg         exec_o,
   output reg  [31:0] instr_o,
   output reg  [31:0] rm_o,
   output reg  [31:0] rs_o,
   output reg  [31:0] alu_o,
   output reg         op2pc_o,
   input  wire        clk_i
);
   // Idle values at time zero
   initial begin
      exec_o = 1'b0;
      instr_o = 32'h0000_0000;
      rm_o = 32'h0000_0000;
      rs_o = 32'h0000_0000;
      alu_o = 32'h0000_0000;
      op2pc_o = 1'b0;
   end
   // One exec cycle, then stale operands are scrambled
   task issue(input [31:0] i, m, s, a, input p);
      @(posedge clk_i);
      exec_o <= 1'b1;
      instr_o <= i;
      rm_o <= m;
      rs_o <= s;
      alu_o <= a;
      op2pc_o <= p;
      @(posedge clk_i);
      exec_o <= 1'b0;
      rm_o <= ~m;
      rs_o <= ~s;
      alu_o <= ~a;
   endtask
endmodule // oss_partner

// File: bench/tb_oss_top.sv
/* Bench for oss_top: scenario tasks, decoder model, bound checker.
   Assumes design, oss_chk and oss_partner are compiled first. */
`timescale 1ns/1ns
module tb_oss_top;
   localparam logic [31:0] PAT = 32'h9234_5679;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, cf = 1'b0;
   logic [3:0]  adr = 4'h0, sel = 4'h0;
   logic [31:0] wd = 32'h0000_0000, q, v, dat, op2, csw, rm, rs, alu, ins;
   logic [31:0] op1, rdd;
   logic        ack, sc, rd_we, pc_we, undef, ex, p2;
   logic [1:0]  cs, cn, ci;
   int          fails = 0, comparisons = 0, tmo = 0;

   oss_partner u_oss_partner (.clk_i(clk_i), .exec_o(ex), .instr_o(ins),
      .rm_o(rm), .rs_o(rs), .alu_o(alu), .op2pc_o(p2));
   oss_top u_oss_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd),
      .dat_o(dat), .ack_o(ack), .exec_i(ex), .instr_i(ins),
      .op1_i(PAT), .operand_register_i(rm),
      .shift_amount_register_i(rs), .op1_is_pc_i(p2), .op2_is_pc_i(p2),
      .instr_addr_i(32'h0000_1000), .alu_result_i(alu),
      .alu_carry_i(1'b1), .alu_ovf_i(1'b0), .op2_o(op2),
      .shift_carry_o(sc), .op1_o(op1), .rd_data_o(rdd), .rd_we_o(rd_we),
      .pc_we_o(pc_we), .undef_o(undef), .cyc_s_o(cs), .cyc_n_o(cn),
      .cyc_i_o(ci), .current_status_word_o(csw));

   // Core clock, 100 ns period
   initial forever #50 clk_i = ~clk_i;

   task stop_test;
      if (fails == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t %h %h", $time, g, e);
      end
   endtask

   // Reference shifter: one step per unit of amount
   function automatic logic [32:0] sh_ref(input logic [1:0] t, input int n,
      input logic r, input logic [31:0] m, input logic c);
      logic [31:0] x;
      logic        k;
      x = m;
      k = c;
      if (!r && n == 0 && t == 2'h3)
         return {m[0], c, m[31:1]};
      if (!r && n == 0 && t != 2'h0)
         n = 32;
      for (int i = 0; i < n; i++) begin
         k = (t == 2'h0) ? x[31] : x[0];
         x = (t == 2'h0) ? x << 1 : (t == 2'h1) ? x >> 1 :
             (t == 2'h2) ? {x[31], x[31:1]} : {x[0], x[31:1]};
      end
      return {k, x};
   endfunction

   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      sel <= 4'h1;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task go(input logic [31:0] i, m, s, a, input logic p);
      u_oss_partner.issue(i, m, s, a, p);
      @(negedge clk_i);
   endtask

   task setc(input logic c);
      go(32'he128_f002, {2'h0, c, 29'h0}, 0, 0, 0);
      cf = c;
      chk(csw, {2'h0, c, 29'h0} | 32'h0000_00d3);
   endtask

   task t_regs;
      wb(0, 4'h4, 0);
      chk(q, 32'h0000_00d3);
      wb(0, 4'h2, 0);
      chk(q, 32'h0000_0000);
      wb(1, 4'h0, 32'h0000_0001);
      wb(0, 4'h0, 0);
      chk(q, 32'h0000_0001);
      wb(1, 4'h4, 32'hffff_ffff);
      chk(csw, 32'h0000_00d3);
   endtask

   task t_imm;
      int          a[4] = '{0, 1, 5, 31};
      logic [32:0] e;
      for (int c = 0; c < 2; c++) begin
         setc(c[0]);
         for (int t = 0; t < 4; t++)
            for (int j = 0; j < 4; j++) begin
               e = sh_ref(t[1:0], a[j], 0, PAT, cf);
               go({20'he_1a01, a[j][4:0], t[1:0], 5'h02}, PAT, 0, 0, 0);
               chk(op2, e[31:0]);
               chk(sc, e[32]);
            end
      end
   endtask

   task t_reg;
      int          a[8] = '{0, 1, 31, 32, 33, 63, 64, 200};
      logic [32:0] e;
      for (int t = 0; t < 4; t++)
         for (int j = 0; j < 8; j++) begin
            e = sh_ref(t[1:0], a[j], 1, PAT, cf);
            go({20'he_1a01, 5'h06, t[1:0], 5'h12}, PAT,
               {24'hff_ffff, a[j][7:0]}, 0, 0);
            chk(op2, e[31:0]);
            chk(sc, e[32]);
            chk(ci, 2'h1);
         end
      go(32'he1a0_1392, PAT, 1, 0, 0);
      chk(undef, 1'b1);
      chk(rd_we, 1'b0);
      for (int r = 0; r < 16; r += 5) begin
         e = sh_ref(2'h3, 2 * r, 1, 32'h0000_0081, cf);
         go({20'he_3a01, r[3:0], 8'h81}, 0, 0, 0, 0);
         chk(op2, e[31:0]);
         chk(sc, e[32]);
      end
   endtask

   task t_flags;
      go(32'he128_f002, 32'h3000_0000, 0, 0, 0);
      go({20'he_1b01, 5'h00, 7'h22}, 32'h0000_0001, 0, 0, 0);
      chk(csw[31:28], 4'h5);
      chk(rd_we, 1'b1);
      go(32'he150_0002, 0, 0, 32'h8000_0000, 0);
      chk(csw[31:28], 4'ha);
      chk(rd_we, 1'b0);
      // Flag update disabled through the control register
      wb(1, 4'h0, 32'h0000_0000);
      go(32'he150_0002, 0, 0, 0, 0);
      chk(csw[31:28], 4'ha);
      wb(1, 4'h0, 32'h0000_0001);
      cf = 1'b1;
   endtask

   task t_pc;
      v = csw;
      go(32'he1a0_f002, 32'h0000_4000, 0, 32'h0000_4000, 0);
      chk(pc_we, 1'b1);
      chk(csw, v);
      chk({cs, cn, ci}, 6'h24);
      go(32'he1a0_f312, 0, 0, 0, 0);
      chk({cs, cn, ci}, 6'h25);
      go(32'he1a0_100f, PAT, 0, 0, 1);
      chk(op2, 32'h0000_1008);
      chk(op1, 32'h0000_1008);
      go(32'he1a0_131f, PAT, 0, 0, 1);
      chk(op2, 32'h0000_100c);
      chk(op1, 32'h0000_100c);
      go(32'he169_f002, 32'h6000_0013, 0, 0, 0);
      wb(0, 4'hc, 0);
      chk(q, 32'h6000_0013);
      go(32'he14f_1000, 0, 0, 0, 0);
      chk(rdd, 32'h6000_0013);
      go(32'he1b0_f002, 0, 0, 0, 0);
      chk(csw, 32'h6000_0013);
      go(32'he128_f002, 32'hf000_0000, 0, 0, 0);
      go(32'he130_f002, 0, 0, 0, 0);
      chk(csw, 32'h6000_0013);
      go(32'he129_f002, 32'h0f00_0010, 0, 0, 0);
      chk(csw, 32'h0000_0010);
      go(32'he129_f002, 32'hf000_00d3, 0, 0, 0);
      chk(csw, 32'hf000_0010);
      go(32'he130_f002, 0, 0, 0, 0);
      chk(csw, 32'hf000_0010);
      go(32'he10f_1000, 0, 0, 0, 0);
      chk(rdd, 32'hf000_0010);
      chk(rd_we, 1'b1);
   endtask

   // Hang guard
   always @(posedge clk_i) begin
      tmo <= tmo + 1;
      if (tmo == 20000) begin
         fails++;
         stop_test;
      end
   end

   // Reset, then the scenarios in turn
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_imm;
      t_reg;
      t_flags;
      t_pc;
      stop_test;
   end
endmodule // tb_oss_top

bind oss_top oss_chk u_oss_chk (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .exec_i(exec_i),
   .instr_i(instr_i), .operand_register_i(operand_register_i),
   .op2_is_pc_i(op2_is_pc_i), .op2_o(op2_o), .shift_carry_o(shift_carry_o),
   .rd_we_o(rd_we_o), .pc_we_o(pc_we_o), .undef_o(undef_o),
   .current_status_word_o(current_status_word_o));
